// ==== src/pio_dev_end.sv ====
// Decided for this implementation: the address map and strobed register access.
`timescale 1ns/100ps
module pio_dev_end #(
   parameter int WORDS_PER_BLOCK = 256,
   parameter int PREP_CYCLES = 8
) (
   // Clock and reset.
   input wire logic i_sys_clk,
   input wire logic i_rstn,
   // Link.
   pio_link_if.device link,
   // Local port.
   input wire logic [3:0] i_addr,
   input wire logic [15:0] i_wdata,
   input wire logic i_wr,
   input wire logic i_rd,
   output logic [15:0] o_rdata,
   // Data source.
   input wire logic [15:0] i_word,
   output logic o_word_take,
   output logic o_cmd_stb,
   output logic [7:0] o_cmd
);

   // ************************************************************
   // State
   // ************************************************************
   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_EXEC = 3'b001,
      ST_PREP = 3'b010,
      ST_RDYI = 3'b011,
      ST_XFER = 3'b100
   } phase_type;

   typedef struct packed {
      phase_type phase;
      logic bsy;
      logic drq;
      logic err;
      logic pend;
      logic intrq;
      logic ident;
      logic cable;
      logic [7:0] cmd;
      logic [7:0] prep_cnt;
      logic [15:0] word_idx;
      logic [15:0] word_lim;
      logic [15:0] blk_left;
      logic done_req;
      logic abort_req;
      logic [15:0] rdata;
      logic [15:0] lrdata;
      logic take;
      logic cmd_stb;
   } state_type;

   state_type s_q;
   state_type s_d;
   logic [15:0] word_out;
   logic data_rd;
   logic status_rd;

   // Decodes of the host strobes.
   assign data_rd = link.rd_stb && (link.sel == proto_pkg::SEL_DATA);
   assign status_rd = link.rd_stb && (link.sel == proto_pkg::SEL_STATUS);

   // Word sent to host: cable bit is patched into identification word.
   always_comb begin
      word_out = i_word;
      if (s_q.ident &&
          s_q.word_idx == 16'(proto_pkg::ID_CABLE_WORD)) begin
         word_out[proto_pkg::ID_CABLE_BIT] = s_q.cable;
      end
   end

   // Next-state logic for the whole device end.
   always_comb begin
      s_d = s_q;
      s_d.take = 1'b0;
      s_d.cmd_stb = 1'b0;
      // Local control writes request completion or abort.
      if (i_wr && i_addr == proto_pkg::DREG_CTRL) begin
         s_d.done_req = i_wdata[0];
         s_d.abort_req = i_wdata[1];
      end
      if (i_wr && i_addr == proto_pkg::DREG_LIMIT) begin
         s_d.word_lim = i_wdata;
      end
      // Host register reads.
      unique case (link.sel)
         proto_pkg::SEL_STATUS, proto_pkg::SEL_ALTSTATUS: begin
            s_d.rdata = {8'h0, s_q.bsy, 3'h0, s_q.drq, 2'h0, s_q.err};
         end
         proto_pkg::SEL_ERROR: begin
            s_d.rdata = {13'h0, s_q.err, 2'h0};
         end
         proto_pkg::SEL_DATA: begin
            s_d.rdata = word_out;
         end
         default: begin
            s_d.rdata = 16'h0;
         end
      endcase
      unique case (s_q.phase)
         ST_IDLE: begin
            if (status_rd) begin
               s_d.pend = 1'b0;
               s_d.intrq = 1'b0;
            end
            if (link.wr_stb && link.sel == proto_pkg::SEL_COUNT) begin
               s_d.blk_left = link.wdata;
            end
            if (link.wr_stb && link.sel == proto_pkg::SEL_STATUS) begin
               s_d.cmd = link.wdata[7:0];
               s_d.cmd_stb = 1'b1;
               s_d.bsy = 1'b1;
               s_d.drq = 1'b0;
               s_d.err = 1'b0;
               s_d.intrq = 1'b0;
               s_d.done_req = 1'b0;
               s_d.abort_req = 1'b0;
               s_d.prep_cnt = 8'h0;
               s_d.word_idx = 16'h0;
               s_d.ident = link.wdata[7] && link.wdata[6];
               if (link.wdata[7]) begin
                  s_d.phase = ST_PREP;
                  s_d.pend = 1'b0;
                  s_d.cable = ~link.cable_detn;
               end else begin
                  s_d.phase = ST_EXEC;
                  s_d.pend = 1'b1;
               end
            end
         end
         ST_EXEC: begin
            if (s_q.done_req || s_q.abort_req) begin
               s_d.err = s_q.abort_req;
               s_d.bsy = 1'b0;
               s_d.intrq = ~link.nien;
               s_d.done_req = 1'b0;
               s_d.abort_req = 1'b0;
               s_d.phase = ST_IDLE;
            end
         end
         ST_PREP: begin
            s_d.prep_cnt = s_q.prep_cnt + 8'h1;
            if (s_q.abort_req) begin
               s_d.err = 1'b1;
               s_d.bsy = 1'b0;
               s_d.pend = 1'b1;
               s_d.intrq = ~link.nien;
               s_d.abort_req = 1'b0;
               s_d.phase = ST_IDLE;
            end else if (s_q.prep_cnt == 8'(PREP_CYCLES - 1)) begin
               s_d.bsy = 1'b0;
               s_d.drq = 1'b1;
               s_d.word_idx = 16'h0;
               if (link.nien) begin
                  s_d.phase = ST_XFER;
               end else begin
                  s_d.pend = 1'b1;
                  s_d.intrq = 1'b1;
                  s_d.phase = ST_RDYI;
               end
            end
         end
         ST_RDYI: begin
            if (status_rd) begin
               s_d.pend = 1'b0;
               s_d.intrq = 1'b0;
               s_d.phase = ST_XFER;
            end
         end
         ST_XFER: begin
            if (data_rd) begin
               s_d.take = 1'b1;
               s_d.word_idx = s_q.word_idx + 16'h1;
               if (s_q.word_idx + 16'h1 >= s_q.word_lim ||
                   s_q.word_idx == 16'(WORDS_PER_BLOCK - 1)) begin
                  s_d.drq = 1'b0;
                  s_d.blk_left = s_q.blk_left - 16'h1;
                  if (s_q.blk_left <= 16'h1) begin
                     s_d.bsy = 1'b0;
                     s_d.pend = 1'b0;
                     s_d.phase = ST_IDLE;
                  end else begin
                     s_d.bsy = 1'b1;
                     s_d.prep_cnt = 8'h0;
                     s_d.phase = ST_PREP;
                  end
               end
            end
         end
         default: begin
            s_d.phase = ST_IDLE;
         end
      endcase
      // Local register reads.
      unique case (i_addr)
         proto_pkg::DREG_STAT: begin
            s_d.lrdata = {8'h0, s_q.bsy, s_q.drq, s_q.err, s_q.pend,
                          s_q.intrq, s_q.phase};
         end
         proto_pkg::DREG_CMD: begin
            s_d.lrdata = {8'h0, s_q.cmd};
         end
         proto_pkg::DREG_WORD: begin
            s_d.lrdata = s_q.word_idx;
         end
         proto_pkg::DREG_LIMIT: begin
            s_d.lrdata = s_q.word_lim;
         end
         default: begin
            s_d.lrdata = 16'h0;
         end
      endcase
      // Local read data stand only in the cycle after the read strobe.
      if (!i_rd) begin
         s_d.lrdata = 16'h0;
      end
   end

   // State register.
   always_ff @(posedge i_sys_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         s_q <= '0;
         s_q.word_lim <= 16'(WORDS_PER_BLOCK);
      end else begin
         s_q <= s_d;
      end
   end

   assign link.rdata = s_q.rdata;
   assign link.intrq = s_q.intrq;
   assign o_rdata = s_q.lrdata;
   assign o_word_take = s_q.take;
   assign o_cmd_stb = s_q.cmd_stb;
   assign o_cmd = s_q.cmd;

endmodule // pio_dev_end

// ==== src/proto_pkg.sv ====
package proto_pkg;

   // ************************************************************
   // Timing
   // ************************************************************
   localparam int CLK_PERIOD_PS = 5000;
   localparam int STATUS_WAIT_NS = 400;
   localparam int BSY_LIMIT_NS = 400;
   // Host wait before a Status read, rounded up to whole cycles.
   localparam int STATUS_WAIT_CYC =
      (STATUS_WAIT_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   // Latest cycle for BSY after a Command write, rounded down.
   localparam int BSY_LIMIT_CYC = (BSY_LIMIT_NS * 1000) / CLK_PERIOD_PS;

   // ************************************************************
   // Register selects on the parallel port
   // ************************************************************
   localparam logic [2:0] SEL_DATA = 3'h0;
   localparam logic [2:0] SEL_ERROR = 3'h1;
   localparam logic [2:0] SEL_COUNT = 3'h2;
   localparam logic [2:0] SEL_STATUS = 3'h7;
   localparam logic [2:0] SEL_ALTSTATUS = 3'h6;

   // ************************************************************
   // Status and Error bit positions
   // ************************************************************
   localparam int ST_BSY = 7;
   localparam int ST_DRQ = 3;
   localparam int ST_ERR = 0;
   localparam int ERR_ABRT = 2;

   // ************************************************************
   // Identification word and cable bit
   // ************************************************************
   localparam int ID_CABLE_WORD = 93;
   localparam int ID_CABLE_BIT = 13;

   // Command classes as coded by the command opcode's top bit.
   localparam logic [7:0] CMD_CLASS_DATAIN = 8'h80;
   // Identification opcodes are flagged by this bit beside the class bit.
   localparam logic [7:0] CMD_IDENT_FLAG = 8'h40;

   // ************************************************************
   // Local port register map (host controller)
   // ************************************************************
   localparam logic [3:0] HREG_CMD = 4'h0;
   localparam logic [3:0] HREG_CTRL = 4'h1;
   localparam logic [3:0] HREG_STAT = 4'h2;
   localparam logic [3:0] HREG_DATA = 4'h3;
   localparam logic [3:0] HREG_WCNT = 4'h4;

   // Local port register map (device controller).
   localparam logic [3:0] DREG_CTRL = 4'h0;
   localparam logic [3:0] DREG_CMD = 4'h1;
   localparam logic [3:0] DREG_STAT = 4'h2;
   localparam logic [3:0] DREG_WORD = 4'h3;
   localparam logic [3:0] DREG_LIMIT = 4'h4;

endpackage

// ==== src/pio_link_if.sv ====
`timescale 1ns/100ps
interface pio_link_if;
   logic [2:0] sel;
   logic wr_stb;
   logic rd_stb;
   logic [15:0] wdata;
   logic [15:0] rdata;
   logic intrq;
   logic nien;
   logic cable_detn;

   modport device (
      input sel, wr_stb, rd_stb, wdata, nien, cable_detn,
      output rdata, intrq
   );
   modport host (
      output sel, wr_stb, rd_stb, wdata, nien,
      input rdata, intrq
   );
endinterface // pio_link_if

// ==== src/pio_host_end.sv ====
`timescale 1ns/100ps
module pio_host_end (
   // Clock and reset.
   input wire logic i_sys_clk,
   input wire logic i_rstn,
   // Link.
   pio_link_if.host link,
   // Local port.
   input wire logic [3:0] i_addr,
   input wire logic [15:0] i_wdata,
   input wire logic i_wr,
   input wire logic i_rd,
   output logic [15:0] o_rdata,
   // Word stream.
   output logic [15:0] o_word,
   output logic o_word_vld
);

   // ************************************************************
   // State
   // ************************************************************
   typedef enum logic [2:0] {
      H_IDLE = 3'b000,
      H_ISSUE = 3'b001,
      H_WINT = 3'b010,
      H_WAIT = 3'b011,
      H_STAT = 3'b100,
      H_CHK = 3'b101,
      H_DATA = 3'b110,
      H_DCHK = 3'b111
   } hphase_type;

   typedef struct packed {
      hphase_type phase;
      logic [7:0] cmd;
      logic nien;
      logic [15:0] blocks;
      logic [15:0] wcnt;
      logic [15:0] widx;
      logic [15:0] bdone;
      logic [8:0] wait_cnt;
      logic busy;
      logic err;
      logic sel_data;
      logic [2:0] sel;
      logic wr_stb;
      logic rd_stb;
      logic [15:0] wdata;
      logic [15:0] word;
      logic word_vld;
      logic [15:0] lrdata;
   } hstate_type;

   hstate_type s_q;
   hstate_type s_d;
   logic datain;

   assign datain = s_q.cmd[7];

   // Next-state logic of the host end.
   always_comb begin
      s_d = s_q;
      s_d.wr_stb = 1'b0;
      s_d.rd_stb = 1'b0;
      s_d.word_vld = 1'b0;
      if (i_wr && i_addr == proto_pkg::HREG_CTRL) begin
         s_d.nien = i_wdata[0];
         s_d.blocks = i_wdata;
      end
      if (i_wr && i_addr == proto_pkg::HREG_WCNT) begin
         s_d.wcnt = i_wdata;
      end
      unique case (s_q.phase)
         H_IDLE: begin
            if (i_wr && i_addr == proto_pkg::HREG_CMD) begin
               s_d.cmd = i_wdata[7:0];
               s_d.busy = 1'b1;
               s_d.err = 1'b0;
               s_d.bdone = 16'h0;
               s_d.sel = proto_pkg::SEL_COUNT;
               s_d.wdata = s_q.blocks;
               s_d.wr_stb = 1'b1;
               s_d.phase = H_ISSUE;
            end
         end
         H_ISSUE: begin
            s_d.sel = proto_pkg::SEL_STATUS;
            s_d.wdata = {8'h0, s_q.cmd};
            s_d.wr_stb = 1'b1;
            s_d.wait_cnt = 9'h0;
            s_d.phase = s_q.nien ? H_WAIT : H_WINT;
         end
         H_WINT: begin
            if (link.intrq) begin
               s_d.phase = H_STAT;
            end
         end
         H_WAIT: begin
            s_d.wait_cnt = s_q.wait_cnt + 9'h1;
            if (s_q.wait_cnt == 9'(proto_pkg::STATUS_WAIT_CYC - 1)) begin
               s_d.phase = H_STAT;
            end
         end
         H_STAT: begin
            s_d.sel = proto_pkg::SEL_STATUS;
            s_d.rd_stb = 1'b1;
            s_d.phase = H_CHK;
         end
         H_CHK: begin
            if (!s_q.rd_stb) begin
               if (link.rdata[proto_pkg::ST_BSY]) begin
                  s_d.phase = H_STAT;
               end else if (datain && link.rdata[proto_pkg::ST_DRQ]) begin
                  s_d.widx = 16'h0;
                  s_d.phase = H_DATA;
               end else begin
                  s_d.err = link.rdata[proto_pkg::ST_ERR] | datain;
                  s_d.busy = 1'b0;
                  s_d.phase = H_IDLE;
               end
            end
         end
         H_DATA: begin
            s_d.sel = proto_pkg::SEL_DATA;
            s_d.rd_stb = 1'b1;
            s_d.phase = H_DCHK;
         end
         H_DCHK: begin
            if (!s_q.rd_stb) begin
               s_d.word = link.rdata;
               s_d.word_vld = 1'b1;
               s_d.widx = s_q.widx + 16'h1;
               if (s_q.widx + 16'h1 >= s_q.wcnt) begin
                  s_d.bdone = s_q.bdone + 16'h1;
                  s_d.wait_cnt = 9'h0;
                  if (s_q.bdone + 16'h1 >= s_q.blocks) begin
                     s_d.busy = 1'b0;
                     s_d.phase = H_IDLE;
                  end else begin
                     s_d.phase = s_q.nien ? H_WAIT : H_WINT;
                  end
               end else begin
                  s_d.phase = H_DATA;
               end
            end
         end
      endcase
      unique case (i_addr)
         proto_pkg::HREG_STAT: begin
            s_d.lrdata = {13'h0, s_q.err, s_q.busy, s_q.nien};
         end
         proto_pkg::HREG_DATA: begin
            s_d.lrdata = s_q.word;
         end
         proto_pkg::HREG_WCNT: begin
            s_d.lrdata = s_q.bdone;
         end
         default: begin
            s_d.lrdata = 16'h0;
         end
      endcase
      // Local read data stand only in the cycle after the read strobe.
      if (!i_rd) begin
         s_d.lrdata = 16'h0;
      end
   end

   // State register.
   always_ff @(posedge i_sys_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         s_q <= '0;
         s_q.wcnt <= 16'h0100;
         s_q.blocks <= 16'h0001;
      end else begin
         s_q <= s_d;
      end
   end

   assign link.sel = s_q.sel;
   assign link.wr_stb = s_q.wr_stb;
   assign link.rd_stb = s_q.rd_stb;
   assign link.wdata = s_q.wdata;
   assign link.nien = s_q.nien;
   assign o_rdata = s_q.lrdata;
   assign o_word = s_q.word;
   assign o_word_vld = s_q.word_vld;

endmodule // pio_host_end

// ==== tb/pio_link_props.sv ====
`timescale 1ns/100ps
module pio_link_props (
   // Clock and reset.
   input wire logic i_sys_clk,
   input wire logic i_rstn,
   // Link.
   input wire logic [2:0] sel,
   input wire logic wr_stb,
   input wire logic rd_stb,
   input wire logic [15:0] rdata,
   input wire logic intrq,
   input wire logic nien
);
   localparam int WAIT_CYC = proto_pkg::STATUS_WAIT_CYC;
   logic st_rd;
   logic cmd_wr;
   logic stat_rd_q;
   logic cmd_q;
   logic seen_q;
   logic drq_q;
   logic [7:0] since_q;

   default clocking cb @(posedge i_sys_clk); endclocking
   default disable iff (!i_rstn);

   // ********
   // Helpers
   // ********
   // Decodes Status reads and Command writes.
   assign st_rd = rd_stb && sel == proto_pkg::SEL_STATUS;
   assign cmd_wr = wr_stb && sel == proto_pkg::SEL_STATUS;

   // Tracks time since a command, interrupts seen and the last DRQ.
   always_ff @(posedge i_sys_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         stat_rd_q <= 1'b0;
         cmd_q <= 1'b0;
         seen_q <= 1'b0;
         drq_q <= 1'b0;
         since_q <= 8'hff;
      end else begin
         stat_rd_q <= st_rd;
         cmd_q <= cmd_wr;
         seen_q <= cmd_wr ? 1'b0 : (seen_q | intrq);
         if (cmd_wr) begin
            drq_q <= 1'b0;
         end else if (stat_rd_q) begin
            drq_q <= rdata[proto_pkg::ST_DRQ];
         end
         if (cmd_wr) begin
            since_q <= 8'h00;
         end else if (since_q != 8'hff) begin
            since_q <= since_q + 8'h01;
         end
      end
   end

   // ***********
   // Assertions
   // ***********
   a_status_wait: assert property (
      st_rd && !intrq && !seen_q |-> since_q >= 8'(WAIT_CYC - 1))
      else $error("status read too soon after command");
   a_read_clears: assert property (
      st_rd && intrq |=> !intrq)
      else $error("interrupt kept after status read");
   a_irq_holds: assert property (
      $fell(intrq) |-> stat_rd_q || cmd_q)
      else $error("interrupt dropped without cause");
   a_rise_needs_en: assert property (
      $rose(intrq) |-> !nien)
      else $error("interrupt raised while disabled");
   a_irq_not_busy: assert property (
      st_rd && intrq |=> !rdata[proto_pkg::ST_BSY])
      else $error("busy shown with interrupt");
   a_drq_not_busy: assert property (
      st_rd |=> !(rdata[proto_pkg::ST_BSY] && rdata[proto_pkg::ST_DRQ]))
      else $error("busy and data request together");
   a_data_needs_drq: assert property (
      rd_stb && sel == proto_pkg::SEL_DATA
      |-> drq_q || (stat_rd_q && rdata[proto_pkg::ST_DRQ]))
      else $error("data read without data request");
   a_cmd_quiets: assert property (
      cmd_wr |=> !intrq [*3])
      else $error("interrupt during command start");

   // Main scenarios.
   c_irq: cover property ($rose(intrq));
   c_ack: cover property (st_rd && intrq);
   c_data: cover property (rd_stb && sel == proto_pkg::SEL_DATA);
endmodule // pio_link_props

// ==== tb/nondata_pio_in_cmd_protocol_tb.sv ====
`timescale 1ns/100ps
module nondata_pio_in_cmd_protocol_tb;
   logic clk, rstn, h_wr, h_rd, d_wr, d_rd, d_take, d_cstb, h_vld;
   logic cable_n, ident_q, irq_q, stat_q, seen;
   logic [3:0] h_addr, d_addr;
   logic [7:0] d_cmd;
   logic [15:0] h_wdata, d_wdata, h_rdata, d_rdata, h_word, d_word;
   logic [15:0] first_st, last_st;
   int err_count, n_checks, word_n, take_n, irq_n, cyc;

   pio_link_if pio_link_if_i ();
   assign pio_link_if_i.cable_detn = cable_n;
   assign d_word = 16'h2a00 + 16'(take_n);

   pio_dev_end #(.WORDS_PER_BLOCK(128), .PREP_CYCLES(8)) pio_dev_end_i (
      .i_sys_clk(clk), .i_rstn(rstn), .link(pio_link_if_i),
      .i_addr(d_addr), .i_wdata(d_wdata), .i_wr(d_wr), .i_rd(d_rd),
      .o_rdata(d_rdata), .i_word(d_word), .o_word_take(d_take),
      .o_cmd_stb(d_cstb), .o_cmd(d_cmd));
   pio_host_end pio_host_end_i (
      .i_sys_clk(clk), .i_rstn(rstn), .link(pio_link_if_i),
      .i_addr(h_addr), .i_wdata(h_wdata), .i_wr(h_wr), .i_rd(h_rd),
      .o_rdata(h_rdata), .o_word(h_word), .o_word_vld(h_vld));
   pio_link_props pio_link_props_i (
      .i_sys_clk(clk), .i_rstn(rstn), .sel(pio_link_if_i.sel),
      .wr_stb(pio_link_if_i.wr_stb), .rd_stb(pio_link_if_i.rd_stb),
      .rdata(pio_link_if_i.rdata), .intrq(pio_link_if_i.intrq),
      .nien(pio_link_if_i.nien));

   // ********
   // Helpers
   // ********
   // Makes the 200 MHz clock.
   always #2.5 clk = ~clk;

   task automatic chk_val(input string nm, input logic [15:0] e,
                          input logic [15:0] g);
      n_checks++;
      if (g !== e) begin
         err_count++;
         $display("unexpected %s: expected %h seen %h", nm, e, g);
      end
   endtask

   task automatic chk_bit(input string nm, input logic e, input logic g);
      n_checks++;
      if (g !== e) begin
         err_count++;
         $display("unexpected %s: expected %b seen %b", nm, e, g);
      end
   endtask

   task automatic results();
      $display("checks %0d mismatches %0d", n_checks, err_count);
      if (err_count == 0 && n_checks > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask

   // Expected stream word; identification word 93 carries the cable bit.
   function automatic logic [15:0] exp_word(input int n);
      logic [15:0] w;
      w = 16'h2a00 + 16'(n);
      if (ident_q && n == proto_pkg::ID_CABLE_WORD)
         w[proto_pkg::ID_CABLE_BIT] = ~cable_n;
      return w;
   endfunction

   // Watches words, interrupts and Status answers; cuts a hang short.
   always @(posedge clk) begin
      cyc++;
      if (cyc == 30000) begin
         err_count++;
         results();
      end
      if (d_take) take_n <= take_n + 1;
      if (h_vld) begin
         chk_val("word", exp_word(word_n), h_word);
         word_n <= word_n + 1;
      end
      if (pio_link_if_i.intrq === 1'b1 && irq_q !== 1'b1) irq_n <= irq_n + 1;
      irq_q <= pio_link_if_i.intrq;
      if (stat_q) begin
         last_st <= pio_link_if_i.rdata;
         if (!seen) first_st <= pio_link_if_i.rdata;
         seen <= 1'b1;
      end
      stat_q <= pio_link_if_i.rd_stb &&
                pio_link_if_i.sel == proto_pkg::SEL_STATUS;
   end

   // Local port cycles.
   task automatic hwr(input logic [3:0] a, input logic [15:0] d);
      @(posedge clk);
      h_addr <= a;
      h_wdata <= d;
      h_wr <= 1'b1;
      @(posedge clk);
      h_wr <= 1'b0;
   endtask

   task automatic dwr(input logic [3:0] a, input logic [15:0] d);
      @(posedge clk);
      d_addr <= a;
      d_wdata <= d;
      d_wr <= 1'b1;
      @(posedge clk);
      d_wr <= 1'b0;
   endtask

   task automatic hrd(input logic [3:0] a, output logic [15:0] d);
      @(posedge clk);
      h_addr <= a;
      h_rd <= 1'b1;
      @(posedge clk);
      h_rd <= 1'b0;
      #1 d = h_rdata;
   endtask

   task automatic drd(input logic [3:0] a, output logic [15:0] d);
      @(posedge clk);
      d_addr <= a;
      d_rd <= 1'b1;
      @(posedge clk);
      d_rd <= 1'b0;
      #1 d = d_rdata;
   endtask

   // ********
   // Tests
   // ********
   // Interrupt-disable bit read back beside an unmapped read.
   task automatic t_regs();
      logic [15:0] d;
      hwr(proto_pkg::HREG_CTRL, 16'h0005);
      hrd(4'hf, d);
      hrd(proto_pkg::HREG_STAT, d);
      chk_val("ctrl", 16'h0001, d);
      $display("test regs done");
   endtask

   // One command; block count bit 0 is the interrupt disable.
   task automatic t_cmd(input logic [7:0] op, input logic [15:0] nblk,
                        input logic [15:0] lim, input logic abort);
      int i;
      int exp_w;
      logic dis;
      logic [15:0] d;
      dis = nblk[0];
      exp_w = (op[7] && !abort) ? nblk * lim : 0;
      word_n = 0;
      take_n = 0;
      irq_n = 0;
      seen = 1'b0;
      ident_q = op[7] & op[6];
      hwr(proto_pkg::HREG_WCNT, lim);
      dwr(proto_pkg::DREG_LIMIT, lim);
      hwr(proto_pkg::HREG_CTRL, nblk);
      hwr(proto_pkg::HREG_CMD, {8'h00, op});
      i = 0;
      while (d_cstb !== 1'b1 && i < 40) begin
         @(posedge clk);
         #1 i++;
      end
      chk_bit("strobe", 1'b1, d_cstb);
      chk_val("command", {8'h00, op}, {8'h00, d_cmd});
      if (abort) dwr(proto_pkg::DREG_CTRL, 16'h0002);
      else if (!op[7]) begin
         repeat (120) @(posedge clk);
         dwr(proto_pkg::DREG_CTRL, 16'h0001);
      end
      i = 0;
      while (i < 3000 && !(exp_w > 0 ? word_n == exp_w :
             seen && last_st[proto_pkg::ST_BSY] === 1'b0)) begin
         @(posedge clk);
         #1 i++;
      end
      chk_bit("finished", 1'b1, i < 3000);
      repeat (100) @(posedge clk);
      #1 chk_val("words", 16'(exp_w), 16'(word_n));
      chk_val("irqs", dis ? 16'h0 : 16'(exp_w > 0 ? nblk : 1),
              16'(irq_n));
      chk_bit("intrq", 1'b0, pio_link_if_i.intrq);
      chk_bit("err", abort, last_st[proto_pkg::ST_ERR]);
      chk_bit("busy", dis && !op[7] && !abort,
              first_st[proto_pkg::ST_BSY]);
      hrd(proto_pkg::HREG_STAT, d);
      chk_val("host status", {13'h0, abort, 1'b0, dis}, d);
      hrd(proto_pkg::HREG_WCNT, d);
      chk_val("blocks", exp_w > 0 ? nblk : 16'h0, d);
      if (exp_w > 0) begin
         hrd(proto_pkg::HREG_DATA, d);
         chk_val("last word", exp_word(exp_w - 1), d);
      end
      drd(proto_pkg::DREG_CMD, d);
      chk_val("device command", {8'h00, op}, d);
      drd(proto_pkg::DREG_STAT, d);
      chk_val("device status", abort ? 16'h0020 : 16'h0, d);
      $display("test command %h done", op);
   endtask

   // Resets the pair and runs every case.
   initial begin
      clk = 1'b0;
      rstn = 1'b0;
      {h_wr, h_rd, d_wr, d_rd, cable_n, ident_q, seen} = '0;
      {h_addr, d_addr, h_wdata, d_wdata} = '0;
      {err_count, n_checks, word_n, take_n, irq_n, cyc} = '0;
      repeat (2) @(posedge clk);
      rstn <= 1'b1;
      t_regs();
      t_cmd(8'h10, 16'h0002, 16'h0004, 1'b0);
      t_cmd(8'h10, 16'h0001, 16'h0004, 1'b0);
      t_cmd(8'h11, 16'h0002, 16'h0004, 1'b1);
      t_cmd(8'h11, 16'h0001, 16'h0004, 1'b1);
      t_cmd(8'h80, 16'h0002, 16'h0004, 1'b0);
      t_cmd(8'h81, 16'h0003, 16'h0004, 1'b0);
      t_cmd(8'h82, 16'h0002, 16'h0004, 1'b1);
      @(posedge clk) cable_n <= 1'b1;
      t_cmd(8'hc0, 16'h0001, 16'h0080, 1'b0);
      @(posedge clk) cable_n <= 1'b0;
      t_cmd(8'hc1, 16'h0001, 16'h0080, 1'b0);
      results();
   end
endmodule // nondata_pio_in_cmd_protocol_tb
